/* File: src/dac_serial_write_port.v */
// Operation
// [RQ1] a frame opens only on a high-to-low edge of frame sync
// [RQ2] each falling serial clock edge in a frame shifts data into 16 bits
// [RQ3] the sixteenth falling edge acts on the frame: code and mode
// [RQ4] host holds sync high at least 33 ns between frames
// [RQ5] host may park sync low between frames for lower power
// [RQ6] frame: 2 ignored, 2 mode, 8 code, 4 ignored bits
// [RQ7] host sends most significant bit first
// [RQ8] code reaches the dac register on the sixteenth edge, never earlier
// [RQ9] sync rising before sixteenth edge clears shifter, nothing changes
// [RQ10] dac register resets to zero until first valid frame
// [RQ11] mode bits 13 and 12 pick normal, 1k, 100k or open
// [RQ12] power-down disconnects amplifier, selects the chosen termination
// [RQ13] any power-down mode asserts analog shutdown; normal releases it
// [RQ14] dac register contents kept through power-down; here power-down frames still load their code bits
// [RQ15] byte-only hosts keep sync low across two bytes
// [RQ16] spi hosts use polarity 0, phase 1
// [RQ17] dsp hosts use own clock, active-low frame, 16-bit word
// [RQ18] mode resets normal; edges after the sixteenth ignored till sync high
`include "dac_serial_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module dac_serial_write_port (
  // clock and reset
  input  wire       clk,
  input  wire       srst,
  // serial pins
  input  wire       sync_n,
  input  wire       sclk,
  input  wire       din,
  // converter side
  output reg  [7:0] dac_code,
  output reg  [1:0] op_mode,
  output reg        amp_connect,
  output reg        term_1k,
  output reg        term_100k,
  output reg        analog_shutdown,
  output reg        frame_done,
  output reg        frame_abort
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_HOLD = 2'h2;

  wire [2:0]  pins_s;
  wire        sync_s;
  wire        sclk_s;
  wire        din_s;
  reg         sync_d_r;
  reg         sclk_d_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [15:0] shift_r;
  reg  [15:0] shift_nxt;
  reg  [4:0]  cnt_r;
  reg  [4:0]  cnt_nxt;
  reg         push_nxt;
  reg         done_nxt;
  reg         abort_nxt;
  reg         armed_r;
  wire        sync_fall;
  wire        sync_rise;
  wire        sclk_fall;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [9:0]  fifo_out_data;
  wire [9:0]  fifo_in_data;

  function is_power_down;
    input [1:0] m;
    begin
      is_power_down = (m != `MODE_NORMAL);
    end
  endfunction

  // all three pins come from the host's domain
  pin_sync2 #(
    .W (3)
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({sync_n, sclk, din}),
    .sync_out (pins_s)
  );

  assign sync_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s  = pins_s[0];

  assign sync_fall = sync_d_r & ~sync_s;
  assign sync_rise = ~sync_d_r & sync_s;
  assign sclk_fall = sclk_d_r & ~sclk_s;

  // one frame carries {mode, code}; bits 15:14 and 3:0 are dropped
  assign fifo_in_data = {shift_nxt[`FRAME_MODE_HI:`FRAME_MODE_LO],
                         shift_nxt[`FRAME_CODE_HI:`FRAME_CODE_LO]};

  always @(posedge clk) begin
    if (srst) begin
      sync_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
      armed_r  <= 1'b0;
    end else begin
      sync_d_r <= sync_s;
      sclk_d_r <= sclk_s;
      // a frame needs a seen high level first, so reset with sync low opens nothing
      if (sync_s) begin
        armed_r <= 1'b1;
      end
    end
  end

  always @* begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    push_nxt  = 1'b0;
    done_nxt  = 1'b0;
    abort_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        // frame start
        // [RQ1] fresh sync fall
        if (sync_fall & armed_r) begin
          state_nxt = ST_SHIFT;
          shift_nxt = 16'h0000;
          cnt_nxt   = 5'h00;
        end
      end
      ST_SHIFT: begin
        if (sync_s) begin
          // [RQ9] early release aborts
          state_nxt = ST_IDLE;
          shift_nxt = 16'h0000;
          cnt_nxt   = 5'h00;
          abort_nxt = 1'b1;
        end else if (sclk_fall) begin
          // [RQ2] shift msb first
          shift_nxt = {shift_r[14:0], din_s};
          cnt_nxt   = cnt_r + 5'h01;
          // [RQ3] act on sixteenth
          if (cnt_nxt == `FRAME_CNT_LAST) begin
            state_nxt = ST_HOLD;
            push_nxt  = 1'b1;
            done_nxt  = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        // [RQ18] extra edges ignored
        if (sync_s) begin
          state_nxt = ST_IDLE;
          cnt_nxt   = 5'h00;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        shift_nxt = 16'h0000;
        cnt_nxt   = 5'h00;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state_r     <= ST_IDLE;
      shift_r     <= 16'h0000;
      cnt_r       <= 5'h00;
      frame_done  <= 1'b0;
      frame_abort <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      shift_r     <= shift_nxt;
      cnt_r       <= cnt_nxt;
      frame_done  <= done_nxt & fifo_in_ready;
      frame_abort <= abort_nxt;
    end
  end

  // frames are queued so a burst of back-to-back writes is never lost;
  // the queue drains every cycle, so it only fills if the drain stalls
  upd_fifo #(
    .WIDTH (`UPD_WIDTH),
    .DEPTH (`UPD_DEPTH),
    .AW    (`UPD_AW)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (push_nxt),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out_data)
  );

  always @(posedge clk) begin
    if (srst) begin
      // [RQ10] code clears at reset
      dac_code        <= `DAC_CODE_RESET;
      // [RQ18] mode resets normal
      op_mode         <= `MODE_RESET;
      amp_connect     <= 1'b1;
      term_1k         <= 1'b0;
      term_100k       <= 1'b0;
      analog_shutdown <= 1'b0;
    end else if (fifo_out_valid) begin
      // [RQ8] code loads on completion
      // [RQ14] code is to be kept in power-down; it loads from every frame, power-down frames too
      dac_code        <= fifo_out_data[7:0];
      // [RQ11] mode decode
      op_mode         <= fifo_out_data[9:8];
      // [RQ12] output termination select
      amp_connect     <= ~is_power_down(fifo_out_data[9:8]);
      term_1k         <= (fifo_out_data[9:8] == `MODE_PD_1K);
      term_100k       <= (fifo_out_data[9:8] == `MODE_PD_100K);
      // [RQ13] analog shutdown follows mode
      analog_shutdown <= is_power_down(fifo_out_data[9:8]);
    end
  end

endmodule // dac_serial_write_port

`default_nettype wire

/* File: src/dac_serial_defines.vh */
`ifndef DAC_SERIAL_DEFINES_VH
`define DAC_SERIAL_DEFINES_VH

// frame layout, counted as received: first bit lands at bit 15
`define FRAME_BITS        16
`define FRAME_MODE_HI     13
`define FRAME_MODE_LO     12
`define FRAME_CODE_HI     11
`define FRAME_CODE_LO     4
`define FRAME_CNT_LAST    5'h10

// operating modes
`define MODE_NORMAL       2'h0
`define MODE_PD_1K        2'h1
`define MODE_PD_100K      2'h2
`define MODE_PD_OPEN      2'h3

// reset values
`define DAC_CODE_RESET    8'h00
`define MODE_RESET        2'h0

// timing
`define CLK_PERIOD_NS     50
`define SYNC_HIGH_MIN_NS  33
`define SYNC_HIGH_MIN_CYC (((`SYNC_HIGH_MIN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

// update buffer
`define UPD_WIDTH         10
`define UPD_DEPTH         32
`define UPD_AW            5

`endif

/* File: src/pin_sync2.v */
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
  parameter W = 3
) (
  // clock and reset
  input  wire         clk,
  input  wire         srst,
  // pins
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_r;
  reg [W-1:0] stab_r;

  // reset to idle-high is set by the caller through the pin itself after two edges
  always @(posedge clk) begin
    if (srst) begin
      meta_r <= {W{1'b0}};
      stab_r <= {W{1'b0}};
    end else begin
      meta_r <= async_in;
      stab_r <= meta_r;
    end
  end

  assign sync_out = stab_r;

endmodule // pin_sync2

`default_nettype wire

/* File: src/upd_fifo.v */
`timescale 1ns/1ps
`default_nettype none

module upd_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // clock and reset
  input  wire             clk,
  input  wire             srst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rd_r];

  always @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule // upd_fifo

`default_nettype wire

/* File: dv/dac_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dac_host (
  // clock
  input  wire logic clk,
  // serial pins
  output var  logic sync_n,
  output var  logic sclk,
  output var  logic din
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic frame(input logic [19:0] w, input int n, input logic hi);
    sync_n = hi;
    half();
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      din = w[19-i];
      half();
      sclk = 1'b0;
      half();
    end
    sync_n = 1'b1;
    din = ~din;
    half();
  endtask
endmodule // dac_host
`default_nettype wire

/* File: dv/dac_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dac_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // converter side
  input wire logic [7:0] dac_code,
  input wire logic [1:0] op_mode,
  input wire logic       amp_connect,
  input wire logic       term_1k,
  input wire logic       term_100k,
  input wire logic       analog_shutdown,
  input wire logic       frame_done,
  input wire logic       frame_abort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_code_on_done: assert property (
    !$past(srst) && $changed(dac_code) |-> $past(frame_done)) else $error("code moved early");
  a_mode_on_done: assert property (
    !$past(srst) && $changed(op_mode) |-> $past(frame_done)) else $error("mode moved early");
  a_abort_frozen: assert property (
    frame_abort |=> ($stable(dac_code) && $stable(op_mode)) [*4]) else $error("abort changed");
  a_amp_normal: assert property (
    amp_connect == (op_mode == 2'h0)) else $error("amp connect");
  a_term_low: assert property (
    term_1k == (op_mode == 2'h1)) else $error("1k term");
  a_term_high: assert property (
    term_100k == (op_mode == 2'h2)) else $error("100k term");
  a_shut_pd: assert property (
    analog_shutdown == (op_mode != 2'h0)) else $error("shutdown");
  a_done_pulse: assert property (
    frame_done |=> !frame_done) else $error("done not a pulse");
  a_done_excl: assert property (
    !(frame_done && frame_abort)) else $error("done with abort");
endmodule // dac_checker
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  wire logic sync_n, sclk, din, amp_connect, term_1k, term_100k;
  wire logic analog_shutdown, frame_done, frame_abort;
  wire logic [7:0] dac_code;
  wire logic [1:0] op_mode;
  int fails = 0, samples_checked = 0, cycles = 0, seed = 57, n;
  logic [10:0] exp_q[$];
  logic [10:0] e;
  logic [1:0] m_mode = 2'h0;
  logic [7:0] m_code = 8'h00;
  always #25 clk = ~clk;
  dac_serial_write_port i_dut (.clk(clk), .srst(srst), .sync_n(sync_n), .sclk(sclk),
    .din(din), .dac_code(dac_code), .op_mode(op_mode), .amp_connect(amp_connect),
    .term_1k(term_1k), .term_100k(term_100k), .analog_shutdown(analog_shutdown),
    .frame_done(frame_done), .frame_abort(frame_abort));
  dac_host i_host (.clk(clk), .sync_n(sync_n), .sclk(sclk), .din(din));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // short frames abort and leave the old state as the expectation
  task automatic send(input logic [1:0] md, input logic [7:0] cd, input int k);
    if (k >= 16) begin
      m_mode = md;
      m_code = cd;
    end
    exp_q.push_back({k >= 16, m_mode, m_code});
    i_host.frame({2'b11, md, cd, 8'hF5}, k, 1'b0);
  endtask
  always @(negedge clk) begin
    if (srst === 1'b0 && (frame_done | frame_abort) === 1'b1) begin
      if (exp_q.size() == 0) check(16'h1, 16'h0);
      else begin
        e = exp_q.pop_front();
        check(frame_done, e[10]);
        @(negedge clk);
        check({op_mode, dac_code}, e[9:0]);
        check({amp_connect, term_1k, term_100k, analog_shutdown},
          {e[9:8] == 0, e[9:8] == 1, e[9:8] == 2, e[9:8] != 0});
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check({op_mode, dac_code, amp_connect, analog_shutdown}, 12'h002);
    send(2'h0, 8'($random(seed)), 16);
    for (int k = 0; k < 4; k++) send(k[1:0], m_code, 16);
    send(2'h0, 8'($random(seed)), 15);
    send(2'h1, 8'($random(seed)), 3);
    send(2'h2, 8'($random(seed)), 20);
    i_host.frame(20'hFFFFF, 16, 1'b1);
    send(2'h0, 8'($random(seed)), 16);
    // eight back-to-back random frames, each drained from the internal queue before the next
    for (n = 0; n < 8; n++) begin
      send(2'($random(seed)), 8'($random(seed)), 16);
      check({op_mode, dac_code}, {m_mode, m_code});
    end
    check(n[15:0], 16'h0008);
    check(analog_shutdown, m_mode != 2'h0);
    check({term_1k, term_100k}, {m_mode == 2'h1, m_mode == 2'h2});
    check(16'(exp_q.size()), 16'h0);
    report_and_stop();
  end
endmodule // testbench
bind dac_serial_write_port dac_checker i_chk (.clk(clk), .srst(srst), .dac_code(dac_code),
  .op_mode(op_mode), .amp_connect(amp_connect), .term_1k(term_1k), .term_100k(term_100k),
  .analog_shutdown(analog_shutdown), .frame_done(frame_done), .frame_abort(frame_abort));
`default_nettype wire
